// File: verilog/mcc_regs.sv
// Host register bank of the motion coprocessor: bus decode, control, results, starts
`timescale 1ns/1ps
//
// Summary of operation
// - Sample registers read twos complement with bit zero always zero (11-bit converter).
// - Writing the forward angle stores it and starts the forward rotation.
// - Writing the reverse angle stores it and starts the reverse rotation.
// - Angles are unsigned fractions of a full turn; full range is 360 degrees.
// - Control bit 3 adds channel U, selecting three-of-three-phase conversion.
// - Control bit 4 adds the auxiliary channel to the conversion group.
// - Control bit 5 halves the internal system clock rate.
// - Control bit 6 enables the rotation-complete interrupt.
// - Control bit 7 enables the conversion-complete interrupt.
// - Control bit 8 picks edge (0) or level (1) interrupt requests.
// - Control bit 10 picks three-of-three or two-of-three reverse rotation.
// - All defined control bits are zero after reset.
// - Status bit 0 sets on conversion complete when its interrupt is enabled.
// - Status bit 1 sets on transformation complete when its interrupt is enabled.
// - Status bit 4 shows valid rotation results.
// - Status bit 11 sets whenever any enabled interrupt source fires.
// - Reading status clears bits 0, 1 and 11 afterwards; bit 4 stays.
// - Status bits 0, 1 and 11 read zero after reset.
// - Four address bits with active-low select and strobes pick ten read and twelve write registers.
// - Write data is captured on the rising edge of the write strobe.
//
module mcc_regs
    import mcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host bus pins
    input wire logic [AW-1:0] addr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output logic data_oe,
    // Open-drain interrupt request pin
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_n_oe,
    // Converter control and results
    output logic conv_u_en,
    output logic conv_aux_en,
    input wire logic conv_done,
    input wire logic [ADC_W-1:0] adc_u,
    input wire logic [ADC_W-1:0] adc_v,
    input wire logic [ADC_W-1:0] adc_w,
    input wire logic [ADC_W-1:0] adc_aux,
    // System clock enable
    output logic sys_tick,
    // Vector transformation engine
    output logic fwd_start,
    output logic rev_start,
    output logic rev_3of3,
    output logic [DW-1:0] forward_angle,
    output logic [DW-1:0] reverse_angle,
    output logic [DW-1:0] direct_axis_input,
    output logic [DW-1:0] quadrature_axis_input,
    output logic [DW-1:0] reverse_transform_in3,
    input wire logic xform_done,
    input wire logic res_valid,
    input wire logic [3:0][DW-1:0] result_word,
    // Timer settings
    output logic [DW-1:0] switching_period,
    output logic [DW-1:0] channel_a_on_time,
    output logic [DW-1:0] channel_b_on_time,
    output logic [DW-1:0] channel_c_on_time,
    output logic [DW-1:0] dead_time_value,
    output logic [DW-1:0] pulse_deletion_value
);
    typedef struct packed {
        mcc_bus_e bus;
        logic [DW-1:0] ctrl;
        logic [NWREG-1:0][DW-1:0] wreg;
        logic [DW-1:0] dout;
        logic doe;
        logic rd_stat;
        logic rd_clr;
        logic fwd_go;
        logic rev_go;
        logic div_phase;
        logic tick;
        logic irq;
    } mcc_regs_s;

    // Every documented reset value of this bank is zero
    localparam mcc_regs_s REGS_RESET = '{
        bus: BUS_IDLE,
        ctrl: CTRL_RESET,
        wreg: {NWREG{WREG_RESET}},
        dout: READ_ZERO,
        doe: 1'b0,
        rd_stat: 1'b0,
        rd_clr: 1'b0,
        fwd_go: 1'b0,
        rev_go: 1'b0,
        div_phase: 1'b0,
        tick: 1'b0,
        irq: 1'b0
    };

    // Whole bank state and its next value
    mcc_regs_s q_ff;
    mcc_regs_s nxt_q;

    // Host pins before and after filtering, and the selected read word
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    logic [AW-1:0] s_addr;
    logic s_cs_n;
    logic s_rd_n;
    logic s_wr_n;
    logic [DW-1:0] s_data;
    logic [DW-1:0] rd_word;

    // Carrier to the status and interrupt unit
    mcc_stat_if sif ();

    // All host pins are asynchronous to clk, so they share one filtered synchroniser
    assign pins_raw = {addr, cs_n, rd_n, wr_n, data_i};

    mcc_pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din(pins_raw),
        .dout(pins_sync)
    );

    // Split the filtered bundle back into its fields
    assign s_addr = pins_sync[SYNC_W-1 -: AW];
    assign s_cs_n = pins_sync[DW + 2];
    assign s_rd_n = pins_sync[DW + 1];
    assign s_wr_n = pins_sync[DW];
    assign s_data = pins_sync[DW-1:0];

    // Status and interrupt unit
    mcc_irq_stat u_stat (
        .clk(clk),
        .reset(reset),
        .sif(sif)
    );

    // Events and enables handed to the status unit
    assign sif.conv_done = conv_done;
    assign sif.xform_done = xform_done;
    assign sif.res_valid = res_valid;
    assign sif.adc_ien = q_ff.ctrl[CB_ADC_IEN];
    assign sif.park_ien = q_ff.ctrl[CB_PARK_IEN];
    assign sif.level_mode = q_ff.ctrl[CB_IRQ_LEVEL];
    assign sif.rd_clr = q_ff.rd_clr;

    // Read data selection; unlisted addresses and spare bits give zero
    always_comb
    begin
        rd_word = READ_ZERO;
        case (s_addr)
            RA_RES0: rd_word = result_word[0];
            RA_RES1: rd_word = result_word[1];
            RA_RES2: rd_word = result_word[2];
            RA_RES3: rd_word = result_word[3];
            RA_V: rd_word = {adc_v, ADC_PAD};
            RA_W: rd_word = {adc_w, ADC_PAD};
            RA_AUX: rd_word = {adc_aux, ADC_PAD};
            RA_U: rd_word = {adc_u, ADC_PAD};
            RA_CTRL: rd_word = q_ff.ctrl & CTRL_WMASK;
            RA_STAT: rd_word = sif.status;
            default: rd_word = READ_ZERO;
        endcase
    end

    // Bus cycle, register writes, transform starts and the clock divider
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.fwd_go = 1'b0;
        nxt_q.rev_go = 1'b0;
        nxt_q.rd_clr = 1'b0;
        case (q_ff.bus)
            BUS_IDLE:
            begin
                if (!s_cs_n && !s_rd_n)
                begin
                    // Word is latched at the start so the read clear cannot alter it
                    nxt_q.bus = BUS_READ;
                    nxt_q.dout = rd_word;
                    nxt_q.doe = 1'b1;
                    nxt_q.rd_stat = (s_addr == RA_STAT);
                end
                else if (!s_cs_n && !s_wr_n)
                begin
                    nxt_q.bus = BUS_WRITE;
                end
            end
            BUS_READ:
            begin
                if (s_rd_n || s_cs_n)
                begin
                    // Flags clear only after the host has taken the word
                    nxt_q.bus = BUS_IDLE;
                    nxt_q.doe = 1'b0;
                    nxt_q.rd_clr = q_ff.rd_stat;
                    nxt_q.rd_stat = 1'b0;
                end
            end
            BUS_WRITE:
            begin
                // Data and address are taken when the strobe returns high
                if (s_wr_n)
                begin
                    nxt_q.bus = BUS_IDLE;
                    case (s_addr)
                        WA_CTRL:
                        begin
                            // Reserved bits are dropped so they read back as zero
                            nxt_q.ctrl = s_data & CTRL_WMASK;
                        end
                        WA_FWD_ANGLE:
                        begin
                            // Angle words are stored raw as fractions of a turn
                            nxt_q.wreg[WA_FWD_ANGLE] = s_data;
                            nxt_q.fwd_go = 1'b1;
                        end
                        WA_REV_ANGLE:
                        begin
                            nxt_q.wreg[WA_REV_ANGLE] = s_data;
                            nxt_q.rev_go = 1'b1;
                        end
                        WA_DEAD, WA_PDEL:
                        begin
                            // Seven-bit timer registers drop their upper bits
                            nxt_q.wreg[s_addr] = s_data & SHORT_MASK;
                        end
                        WA_XIN1, WA_XIN2, WA_XIN3, WA_PERIOD, WA_ON_A, WA_ON_B, WA_ON_C:
                        begin
                            nxt_q.wreg[s_addr] = s_data;
                        end
                        default:
                        begin
                            // Reserved write addresses change nothing
                            nxt_q.bus = BUS_IDLE;
                        end
                    endcase
                end
            end
            default:
            begin
                nxt_q.bus = BUS_IDLE;
                nxt_q.doe = 1'b0;
            end
        endcase

        // Divide by two gives every other cycle; otherwise every cycle is a tick
        if (q_ff.ctrl[CB_CLK_DIV2])
        begin
            nxt_q.div_phase = ~q_ff.div_phase;
            nxt_q.tick = q_ff.div_phase;
        end
        else
        begin
            nxt_q.div_phase = 1'b0;
            nxt_q.tick = 1'b1;
        end

        // Request line registered again so the pin comes from a flop here
        nxt_q.irq = sif.irq_req;
    end

    // Single synchronous reset for the whole bank
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q_ff <= REGS_RESET;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // Host data bus
    assign data_o = q_ff.dout;
    assign data_oe = q_ff.doe;

    // Open drain: the pin is only ever pulled low, the pull-up supplies high
    assign irq_n_o = 1'b0;
    assign irq_n_oe = q_ff.irq;

    // Converter channel selection
    assign conv_u_en = q_ff.ctrl[CB_U_EN];
    assign conv_aux_en = q_ff.ctrl[CB_AUX_EN];

    // Internal rate
    assign sys_tick = q_ff.tick;

    // Transformation engine controls; the first two inputs double as direct/quadrature
    assign fwd_start = q_ff.fwd_go;
    assign rev_start = q_ff.rev_go;
    assign rev_3of3 = q_ff.ctrl[CB_REV_3OF3];
    assign forward_angle = q_ff.wreg[WA_FWD_ANGLE];
    assign reverse_angle = q_ff.wreg[WA_REV_ANGLE];
    assign direct_axis_input = q_ff.wreg[WA_XIN1];
    assign quadrature_axis_input = q_ff.wreg[WA_XIN2];
    assign reverse_transform_in3 = q_ff.wreg[WA_XIN3];

    // Timer settings
    assign switching_period = q_ff.wreg[WA_PERIOD];
    assign channel_a_on_time = q_ff.wreg[WA_ON_A];
    assign channel_b_on_time = q_ff.wreg[WA_ON_B];
    assign channel_c_on_time = q_ff.wreg[WA_ON_C];
    assign dead_time_value = q_ff.wreg[WA_DEAD];
    assign pulse_deletion_value = q_ff.wreg[WA_PDEL];
endmodule

// File: verilog/mcc_pkg.sv
// Shared constants and types for the motion coprocessor register bank
package mcc_pkg;
    // Bus and data widths
    localparam int DW = 12;
    localparam int AW = 4;
    localparam int ADC_W = 11;
    localparam int SYNC_W = AW + 3 + DW;
    localparam int NWREG = 11;

    // Write map addresses
    localparam logic [AW-1:0] WA_REV_ANGLE = 4'h0;
    localparam logic [AW-1:0] WA_XIN1 = 4'h1;
    localparam logic [AW-1:0] WA_XIN2 = 4'h2;
    localparam logic [AW-1:0] WA_XIN3 = 4'h3;
    localparam logic [AW-1:0] WA_FWD_ANGLE = 4'h4;
    localparam logic [AW-1:0] WA_PERIOD = 4'h5;
    localparam logic [AW-1:0] WA_ON_A = 4'h6;
    localparam logic [AW-1:0] WA_ON_B = 4'h7;
    localparam logic [AW-1:0] WA_ON_C = 4'h8;
    localparam logic [AW-1:0] WA_DEAD = 4'h9;
    localparam logic [AW-1:0] WA_PDEL = 4'ha;
    localparam logic [AW-1:0] WA_CTRL = 4'hd;

    // Read map addresses
    localparam logic [AW-1:0] RA_RES0 = 4'h0;
    localparam logic [AW-1:0] RA_RES1 = 4'h1;
    localparam logic [AW-1:0] RA_RES2 = 4'h2;
    localparam logic [AW-1:0] RA_RES3 = 4'h3;
    localparam logic [AW-1:0] RA_V = 4'h5;
    localparam logic [AW-1:0] RA_W = 4'h6;
    localparam logic [AW-1:0] RA_AUX = 4'h7;
    localparam logic [AW-1:0] RA_U = 4'h8;
    localparam logic [AW-1:0] RA_CTRL = 4'hd;
    localparam logic [AW-1:0] RA_STAT = 4'he;

    // Control field positions, writable mask and reset
    localparam int CB_U_EN = 3;
    localparam int CB_AUX_EN = 4;
    localparam int CB_CLK_DIV2 = 5;
    localparam int CB_PARK_IEN = 6;
    localparam int CB_ADC_IEN = 7;
    localparam int CB_IRQ_LEVEL = 8;
    localparam int CB_REV_3OF3 = 10;
    localparam logic [DW-1:0] CTRL_WMASK = 12'h5f8;
    localparam logic [DW-1:0] CTRL_RESET = 12'h000;

    // Status field positions and reset
    localparam int SB_CONV = 0;
    localparam int SB_XFORM = 1;
    localparam int SB_VALID = 4;
    localparam int SB_IRQ = 11;
    localparam logic [DW-1:0] STAT_RESET = 12'h000;

    // Seven-bit timer registers and other fill values
    localparam logic [DW-1:0] SHORT_MASK = 12'h07f;
    localparam logic [DW-1:0] WREG_RESET = 12'h000;
    localparam logic [DW-1:0] READ_ZERO = 12'h000;
    localparam logic ADC_PAD = 1'b0;

    // Host bus cycle state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_WRITE = 2'b10
    } mcc_bus_e;
endpackage

// File: verilog/mcc_stat_if.sv
// Carrier between the register core and the status/interrupt unit
`timescale 1ns/1ps
interface mcc_stat_if;
    import mcc_pkg::*;
    logic conv_done;
    logic xform_done;
    logic res_valid;
    logic adc_ien;
    logic park_ien;
    logic level_mode;
    logic rd_clr;
    logic [DW-1:0] status;
    logic irq_req;

    modport core (
        output conv_done, xform_done, res_valid, adc_ien, park_ien, level_mode, rd_clr,
        input status, irq_req
    );
    modport unit (
        input conv_done, xform_done, res_valid, adc_ien, park_ien, level_mode, rd_clr,
        output status, irq_req
    );
endinterface

// File: verilog/mcc_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module mcc_pin_sync
    import mcc_pkg::*;
#(
    parameter int W = SYNC_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw pins and filtered result
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } mcc_sync_s;

    localparam mcc_sync_s SYNC_RESET = '1;

    mcc_sync_s q_ff;
    mcc_sync_s nxt_q;

    // Stage one feeds only stage two; each bit updates only where two and three agree
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.s1 = din;
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        nxt_q.stable = (~(q_ff.s2 ^ q_ff.s3) & q_ff.s3) | ((q_ff.s2 ^ q_ff.s3) & q_ff.stable);
    end

    // Idle high so strobes read inactive out of reset
    always_ff @(posedge clk)
    begin
        if (reset)
            q_ff <= SYNC_RESET;
        else
            q_ff <= nxt_q;
    end

    assign dout = q_ff.stable;
endmodule

// File: verilog/mcc_irq_stat.sv
// Status flags and interrupt request generation
`timescale 1ns/1ps
module mcc_irq_stat
    import mcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Link to the register core
    mcc_stat_if.unit sif
);
    typedef struct packed {
        logic [DW-1:0] stat;
        logic irq;
    } mcc_irq_s;

    localparam mcc_irq_s IRQ_RESET = '{stat: STAT_RESET, irq: 1'b0};

    mcc_irq_s q_ff;
    mcc_irq_s nxt_q;
    logic set_conv;
    logic set_xform;
    logic set_any;

    // Sticky flags: a set in the clearing cycle wins over the read clear
    always_comb
    begin
        set_conv = sif.conv_done & sif.adc_ien;
        set_xform = sif.xform_done & sif.park_ien;
        set_any = set_conv | set_xform;
        nxt_q = IRQ_RESET;
        nxt_q.stat[SB_CONV] = set_conv | (q_ff.stat[SB_CONV] & ~sif.rd_clr);
        nxt_q.stat[SB_XFORM] = set_xform | (q_ff.stat[SB_XFORM] & ~sif.rd_clr);
        nxt_q.stat[SB_IRQ] = set_any | (q_ff.stat[SB_IRQ] & ~sif.rd_clr);
        nxt_q.stat[SB_VALID] = sif.res_valid;
        // Level mode follows the source flag; edge mode pulses once per event
        nxt_q.irq = sif.level_mode ? nxt_q.stat[SB_IRQ] : set_any;
    end

    // Flags start clear
    always_ff @(posedge clk)
    begin
        if (reset)
            q_ff <= IRQ_RESET;
        else
            q_ff <= nxt_q;
    end

    assign sif.status = q_ff.stat;
    assign sif.irq_req = q_ff.irq;
endmodule

// File: sim/mcc_regs_sva.sv
// Concurrent checks on the register bank top-level ports
`timescale 1ns/1ps
module mcc_regs_sva
    import mcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host bus pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DW-1:0] data_o,
    input wire logic data_oe,
    // Interrupt pin
    input wire logic irq_n_o,
    input wire logic irq_n_oe,
    // Engine and converter side
    input wire logic conv_u_en,
    input wire logic rev_3of3,
    input wire logic conv_done,
    input wire logic xform_done,
    input wire logic sys_tick,
    input wire logic fwd_start,
    input wire logic rev_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // First edge after release must still show the reset state
    a_reset_quiet: assert property ($fell(reset) |-> !data_oe && !irq_n_oe && !fwd_start
        && !conv_u_en && !rev_3of3 && data_o == 12'h000) else $error("state not reset");
    a_fwd_pulse: assert property (fwd_start |=> !fwd_start)
        else $error("forward start longer than one cycle");
    a_rev_pulse: assert property (rev_start |=> !rev_start)
        else $error("reverse start longer than one cycle");
    // Start only after the write strobe has gone back high
    a_start_after_wr: assert property ($rose(fwd_start) |-> wr_n && $past(wr_n, 2))
        else $error("forward start before strobe release");
    // Tick is never low two cycles running, divided or not
    a_tick_rate: assert property (!sys_tick |=> sys_tick)
        else $error("system tick missed");
    a_oe_on_read: assert property ($rose(data_oe) |-> !cs_n && !rd_n)
        else $error("bus driven without read");
    a_oe_release: assert property ($rose(rd_n) |-> ##[1:8] !data_oe)
        else $error("bus still driven after read");
    a_irq_cause: assert property ($rose(irq_n_oe) |-> $past(conv_done, 2)
        || $past(xform_done, 2)) else $error("interrupt without event");
    a_irq_pin_low: assert property (irq_n_oe |-> irq_n_o == 1'b0)
        else $error("interrupt pin not pulled low");

    // Main scenarios reached
    c_fwd: cover property ($rose(fwd_start));
    c_rev: cover property ($rose(rev_start));
    c_irq: cover property ($rose(irq_n_oe));
    c_read: cover property ($rose(data_oe));
endmodule

bind mcc_regs mcc_regs_sva i_sva (.clk(clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_o(data_o), .data_oe(data_oe), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .conv_u_en(conv_u_en), .rev_3of3(rev_3of3), .conv_done(conv_done),
    .xform_done(xform_done), .sys_tick(sys_tick), .fwd_start(fwd_start),
    .rev_start(rev_start));

// File: sim/mcc_host_bfm.sv
// Host processor model on the parallel register bus
`timescale 1ns/1ps
module mcc_host_bfm
    import mcc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus pins toward the device
    output logic [AW-1:0] addr,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [DW-1:0] data,
    // Device read side
    input wire logic [DW-1:0] rdata,
    input wire logic oe
);
    // Idle bus at time zero
    initial
    begin
        addr = 4'h0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data = 12'h000;
    end

    // Long strobe, data held well past the rising edge since pins are filtered
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        data <= ~d;
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        // Wrong word at the falling strobe; only the word at its rising edge may land
        repeat (2) @(posedge clk);
        data <= d;
        repeat (4) @(posedge clk);
        wr_n <= 1'b1;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        data <= ~d; // Released bus must not keep the old value
        repeat (5) @(posedge clk);
    endtask

    // Hold the read until the device drives, take data at that edge after
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
        int n;
        @(posedge clk);
        addr <= a;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (oe !== 1'b1 && n < 20);
        @(posedge clk);
        // A read that never got an answer returns unknowns so its compare fails
        q = (oe === 1'b1) ? rdata : {DW{1'bx}};
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the motion coprocessor register bank
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_top
    import mcc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [AW-1:0] addr;
    logic cs_n, rd_n, wr_n, data_oe, irq_n_o, irq_n_oe, sys_tick;
    logic [DW-1:0] data_i, data_o;
    logic conv_u_en, conv_aux_en, fwd_start, rev_start, rev_3of3;
    logic conv_done = 1'b0;
    logic xform_done = 1'b0;
    logic res_valid = 1'b0;
    logic [ADC_W-1:0] smp[4] = '{default: 11'h000};
    logic [3:0][DW-1:0] result_word = '0;
    logic [DW-1:0] fa, ra, dq, qq, r3, sp, ca, cb, cc, dt, pd;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int n_fwd = 0;
    int n_rev = 0;
    int n_irq = 0;
    int unsigned m_reg[16];

    always #12.5 clk = ~clk;

    mcc_host_bfm host (.clk(clk), .addr(addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .data(data_i), .rdata(data_o), .oe(data_oe));

    mcc_regs i_dut (.clk(clk), .reset(reset), .addr(addr), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
        .irq_n_i(irq_n_oe ? 1'b0 : 1'b1), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
        .conv_u_en(conv_u_en), .conv_aux_en(conv_aux_en), .conv_done(conv_done),
        .adc_u(smp[0]), .adc_v(smp[1]), .adc_w(smp[2]), .adc_aux(smp[3]),
        .sys_tick(sys_tick), .fwd_start(fwd_start), .rev_start(rev_start),
        .rev_3of3(rev_3of3), .forward_angle(fa), .reverse_angle(ra), .direct_axis_input(dq),
        .quadrature_axis_input(qq), .reverse_transform_in3(r3), .xform_done(xform_done),
        .res_valid(res_valid), .result_word(result_word), .switching_period(sp),
        .channel_a_on_time(ca), .channel_b_on_time(cb), .channel_c_on_time(cc),
        .dead_time_value(dt), .pulse_deletion_value(pd));

    // Pulse and interrupt monitors, plus the hang guard
    always @(posedge clk)
    begin
        cyc++;
        n_fwd += (fwd_start === 1'b1);
        n_rev += (rev_start === 1'b1);
        n_irq += (irq_n_oe === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Write side outputs in write-map order
    function automatic logic [DW-1:0] wout(int a);
        logic [DW-1:0] o[11];
        o = '{ra, dq, qq, r3, fa, sp, ca, cb, cc, dt, pd};
        return o[a];
    endfunction

    // One event pulse, then read status against the model
    task automatic event_stat(input bit xf, input int unsigned exp);
        logic [DW-1:0] q;
        @(posedge clk);
        if (xf)
            xform_done <= 1'b1;
        else
            conv_done <= 1'b1;
        @(posedge clk);
        xform_done <= 1'b0;
        conv_done <= 1'b0;
        repeat (20) @(posedge clk);
        host.rd(RA_STAT, q);
        `CHK(q, exp[DW-1:0])
    endtask

    initial
    begin
        logic [DW-1:0] q, d;
        int i, t;
        void'($urandom(48769));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(sys_tick, 1'b1)
        host.rd(RA_CTRL, q);
        `CHK(q, CTRL_RESET)
        host.rd(RA_STAT, q);
        `CHK(q, STAT_RESET)
        // Random control words, bit 5 kept set for the halved clock, low bits zero
        for (i = 0; i < 4; i++)
        begin
            d = (12'($urandom) | 12'h020) & 12'hefc;
            host.wr(WA_CTRL, d);
            host.rd(RA_CTRL, q);
            `CHK(q, d & 12'h5f8)
            `CHK(conv_u_en, d[3])
            `CHK(conv_aux_en, d[4])
            `CHK(rev_3of3, d[10])
        end
        t = 0;
        repeat (20)
        begin
            @(posedge clk);
            t += (sys_tick === 1'b1);
        end
        `CHK(t, 10)
        host.wr(WA_CTRL, 12'h420);
        for (i = 0; i < 11; i++)
        begin
            d = 12'($urandom);
            m_reg[i] = (i >= 9) ? d & SHORT_MASK : d;
            host.wr(i[AW-1:0], d);
            `CHK(wout(i), m_reg[i][DW-1:0])
        end
        `CHK(n_fwd, 1)
        `CHK(n_rev, 1)
        host.wr(WA_FWD_ANGLE, 12'h200);
        host.wr(WA_REV_ANGLE, 12'h400);
        host.wr(4'hb, 12'hfff);
        `CHK(fa, 12'h200)
        `CHK(ra, 12'h400)
        `CHK(n_fwd + n_rev, 4)
        // Samples and results through the read map
        @(posedge clk);
        for (i = 0; i < 4; i++)
        begin
            smp[i] <= 11'($urandom);
            result_word[i] <= 12'($urandom);
        end
        @(posedge clk);
        for (i = 0; i < 4; i++)
        begin
            host.rd(i[AW-1:0], q);
            `CHK(q, result_word[i])
        end
        host.rd(RA_U, q);
        `CHK(q, {smp[0], 1'b0})
        for (i = 1; i < 4; i++)
        begin
            host.rd(RA_V + AW'(i - 1), q);
            `CHK(q, {smp[i], 1'b0})
        end
        foreach (m_reg[i])
        begin
            if (i == 4 || (i >= 9 && i <= 12) || i == 15)
            begin
                host.rd(i[AW-1:0], q);
                `CHK(q, READ_ZERO)
            end
        end
        // Edge-mode conversion interrupt, then clear on read
        host.wr(WA_CTRL, 12'h4a0);
        res_valid <= 1'b1;
        n_irq = 0;
        event_stat(1'b0, 32'h811);
        `CHK(n_irq, 1)
        host.rd(RA_STAT, q);
        `CHK(q, 12'h010)
        host.wr(WA_CTRL, 12'h420);
        event_stat(1'b0, 32'h010);
        event_stat(1'b1, 32'h010);
        // Level-mode transformation interrupt holds until status is read
        host.wr(WA_CTRL, 12'h560);
        n_irq = 0;
        event_stat(1'b1, 32'h812);
        `CHK(n_irq > 20, 1'b1)
        host.rd(RA_STAT, q);
        `CHK(q, 12'h010)
        `CHK(irq_n_oe, 1'b0)
        complete_run();
    end
endmodule
